// *** amx_pkg.sv ***
// Constants, types and helpers shared by the address/data pin mux and its helpers.
// Assumes one core clock (pclk) and an active-low asynchronous reset (presetn).
// Notes on behaviour
// - Pins become flag lines only with control bit 20 set and port disabled.
// - Pins 0-7 serve flags 8-15, pins 8-15 serve flags 0-7, order kept.
// - Boot straps 00 SPI slave, 01 SPI master, 10 parallel EPROM, 11 ROM only.
// - Ratio straps 00 give 3:1, 01 16:1, 10 8:1; 11 is reserved.
// - 8-bit mode, strobe high: address 15-8 on pins 7-0, 23-16 on 15-8.
// - 8-bit mode, strobe low: address 7-0 on pins 15-8, data on pins 7-0.
// - 16-bit mode, strobe high: address 15-0 on pins 15-0 in place.
// - 16-bit mode, strobe low: data 15-0 on pins 15-0 in place.
// - Read, write and latch strobes are always driven, never released.
// - After reset release wait 4096 input clocks, then start execution.
package amx_pkg;

  localparam int unsigned PIN_W = 16;

  // APB register byte offsets.
  localparam logic [7:0] OFS_SYS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAG_OUT = 8'h04;
  localparam logic [7:0] OFS_FLAG_OE  = 8'h08;
  localparam logic [7:0] OFS_FLAG_IN  = 8'h0c;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h10;
  localparam logic [7:0] OFS_BUS_DATA = 8'h14;
  localparam logic [7:0] OFS_BUS_CMD  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;

  // Field positions.
  localparam int unsigned PORT_EN_BIT   = 0;
  localparam int unsigned WIDTH16_BIT   = 1;
  localparam int unsigned FLAG_MODE_BIT = 20;
  localparam int unsigned CMD_GO_BIT    = 0;
  localparam int unsigned CMD_READ_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_RUN_BIT    = 1;
  localparam int unsigned ST_RSV_BIT    = 2;
  localparam int unsigned ST_BOOT_LSB   = 4;
  localparam int unsigned ST_RATIO_LSB  = 8;

  localparam logic [31:0] SYS_CTRL_MASK = 32'h0010_0003;
  localparam logic [31:0] SYS_CTRL_RST  = 32'h0000_0000;

  // Timing: clock multiplier lock wait, in input clocks, counted on pclk.
  localparam int unsigned LOCK_CYCLES   = 4096;
  localparam int unsigned ALE_CYCLES    = 2;
  localparam int unsigned SETUP_CYCLES  = 1;
  localparam int unsigned STROBE_CYCLES = 6;

  typedef enum logic [1:0] {
    boot_spi_slave, boot_spi_master, boot_parallel_eprom, boot_internal_rom
  } amx_boot_type;

  typedef enum logic [1:0] {
    ratio_3to1, ratio_16to1, ratio_8to1, ratio_reserved
  } amx_ratio_type;

  typedef struct packed {
    logic [PIN_W-1:0] dout;
    logic [PIN_W-1:0] oe;
  } amx_pin_drive_type;

  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
  } amx_strobe_type;

  localparam amx_strobe_type STROBE_IDLE = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};

  // Swaps the two byte groups; the mapping is its own inverse.
  function automatic logic [PIN_W-1:0] amx_swap(input logic [PIN_W-1:0] v);
    return {v[7:0], v[15:8]};
  endfunction : amx_swap

endpackage : amx_pkg

// *** amx_sync.sv ***
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to pclk; output settles 4 to 5 edges after a change.
module amx_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] value_q
);
  import amx_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Only the second and third stages are compared; the first is never read here.
  for (genvar i = 0; i < W; i++) begin : g_lane
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        value_q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        value_q[i] <= s3_q[i];
      end
    end
  end

endmodule : amx_sync

// *** amx_strap_lock.sv ***
// Strap capture and clock-multiplier lock wait.
// Assumes straps arrive already synchronised to pclk and are steady around reset.
module amx_strap_lock (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Synchronised straps
  input  wire logic [1:0]    boot_sync,
  input  wire logic [1:0]    ratio_sync,
  // Decoded results
  output amx_pkg::amx_boot_type  boot_q,
  output amx_pkg::amx_ratio_type ratio_q,
  output logic               locked_q
);
  import amx_pkg::*;

  logic [12:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!locked_q) begin
      cnt_q <= cnt_q + 13'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b0;
    end else if (cnt_q == 13'(LOCK_CYCLES - 1)) begin
      locked_q <= 1'b1;
    end
  end

  // A flop under asynchronous reset may not load a port, so the straps are
  // tracked by the clock through the lock wait and frozen once it ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q  <= boot_spi_slave;
      ratio_q <= ratio_3to1;
    end else if (!locked_q) begin
      boot_q  <= amx_boot_type'(boot_sync);
      ratio_q <= amx_ratio_type'(ratio_sync);
    end
  end

  a_lock_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(locked_q) |-> cnt_q == 13'(LOCK_CYCLES))
    else $error("lock ended at the wrong count");

endmodule : amx_strap_lock

// *** amx_addr_data_mux.sv ***
// Address/data pin mux: flag mode, 8/16-bit bus cycles, strap decode, APB registers.
// Assumes an APB master on pclk; pins and straps are asynchronous and synchronised here.
module amx_addr_data_mux (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic [7:0]                 paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Address/data pins
  input  wire logic [amx_pkg::PIN_W-1:0]  addr_data_pins_in,
  output amx_pkg::amx_pin_drive_type      addr_data_pins_drive,
  output amx_pkg::amx_strobe_type         bus_strobes,
  // Straps and start-up
  input  wire logic [1:0]                 boot_select_straps,
  input  wire logic [1:0]                 core_ratio_straps,
  output amx_pkg::amx_boot_type           boot_mode,
  output amx_pkg::amx_ratio_type          core_ratio,
  output logic                            core_run
);
  import amx_pkg::*;

  typedef enum logic [1:0] {st_idle, st_addr, st_setup, st_strobe} amx_state_type;

  logic [31:0]        sys_ctrl_q;
  logic [PIN_W-1:0]   flag_out_q;
  logic [PIN_W-1:0]   flag_oe_q;
  logic [23:0]        bus_addr_q;
  logic [15:0]        bus_data_q;
  logic [PIN_W-1:0]   pins_sync;
  logic [3:0]         straps_sync;
  amx_state_type      state_q;
  amx_state_type      state_d;
  logic [2:0]         cnt_q;
  logic [23:0]        xaddr_q;
  logic [15:0]        xdata_q;
  logic               xrd_q;
  logic               xwide_q;
  amx_pin_drive_type  pin_d;
  amx_strobe_type     strobe_d;
  logic [31:0]        rdata_d;
  logic               unmapped_d;
  logic               flag_en;
  logic               port_en;
  logic               acc_done;
  logic               wr_en;
  logic               go;
  logic               capture;

  // Synchronisers and strap capture.
  amx_sync #(.W(PIN_W)) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (addr_data_pins_in),
    .value_q (pins_sync)
  );

  amx_sync #(.W(4)) u_strap_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({boot_select_straps, core_ratio_straps}),
    .value_q (straps_sync)
  );

  amx_strap_lock u_strap_lock (
    .pclk       (pclk),
    .presetn    (presetn),
    .boot_sync  (straps_sync[3:2]),
    .ratio_sync (straps_sync[1:0]),
    .boot_q     (boot_mode),
    .ratio_q    (core_ratio),
    .locked_q   (core_run)
  );

  assign port_en  = sys_ctrl_q[PORT_EN_BIT];
  assign flag_en  = sys_ctrl_q[FLAG_MODE_BIT] && !port_en;
  assign acc_done = psel && penable && pready;
  assign wr_en    = acc_done && pwrite && !pslverr;
  assign go       = wr_en && (paddr == OFS_BUS_CMD) && pwdata[CMD_GO_BIT]
                    && state_q == st_idle && port_en && core_run;
  assign capture  = state_q == st_strobe && xrd_q && cnt_q == 3'(STROBE_CYCLES - 1);

  // APB: one wait state, so every answer comes from a flop.
  always_comb begin
    rdata_d    = '0;
    unmapped_d = 1'b0;
    case (paddr)
      OFS_SYS_CTRL: rdata_d = sys_ctrl_q;
      OFS_FLAG_OUT: rdata_d = {16'h0000, flag_out_q};
      OFS_FLAG_OE:  rdata_d = {16'h0000, flag_oe_q};
      OFS_FLAG_IN:  rdata_d = {16'h0000, amx_swap(pins_sync)};
      OFS_BUS_ADDR: rdata_d = {8'h00, bus_addr_q};
      OFS_BUS_DATA: rdata_d = {16'h0000, bus_data_q};
      OFS_BUS_CMD:  rdata_d = '0;
      OFS_STATUS: begin
        rdata_d[ST_BUSY_BIT] = state_q != st_idle;
        rdata_d[ST_RUN_BIT]  = core_run;
        rdata_d[ST_RSV_BIT]  = core_ratio == ratio_reserved;
        rdata_d[ST_BOOT_LSB +: 2]  = boot_mode;
        rdata_d[ST_RATIO_LSB +: 2] = core_ratio;
      end
      default: unmapped_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && unmapped_d;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_ctrl_q <= SYS_CTRL_RST;
    end else if (wr_en && paddr == OFS_SYS_CTRL) begin
      sys_ctrl_q <= pwdata & SYS_CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_out_q <= '0;
      flag_oe_q  <= '0;
      bus_addr_q <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_FLAG_OUT) flag_out_q <= pwdata[15:0];
      if (paddr == OFS_FLAG_OE)  flag_oe_q  <= pwdata[15:0];
      if (paddr == OFS_BUS_ADDR) bus_addr_q <= pwdata[23:0];
    end
  end

  // Read data returned by the pins wins over a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_data_q <= '0;
    end else if (capture) begin
      bus_data_q <= xwide_q ? pins_sync : {8'h00, pins_sync[7:0]};
    end else if (wr_en && paddr == OFS_BUS_DATA && state_q == st_idle) begin
      bus_data_q <= pwdata[15:0];
    end
  end

  // Bus cycle sequencer. Disabling the port aborts a cycle in flight.
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle:   if (go) state_d = st_addr;
      st_addr:   if (cnt_q == 3'(ALE_CYCLES - 1)) state_d = st_setup;
      st_setup:  if (cnt_q == 3'(SETUP_CYCLES - 1)) state_d = st_strobe;
      st_strobe: if (cnt_q == 3'(STROBE_CYCLES - 1)) state_d = st_idle;
      default:   state_d = st_idle;
    endcase
    if (!port_en) state_d = st_idle;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xaddr_q <= '0;
      xdata_q <= '0;
      xrd_q   <= 1'b0;
      xwide_q <= 1'b0;
    end else if (go) begin
      xaddr_q <= bus_addr_q;
      xdata_q <= bus_data_q;
      xrd_q   <= pwdata[CMD_READ_BIT];
      xwide_q <= sys_ctrl_q[WIDTH16_BIT];
    end
  end

  // Pin drive follows the next state so the pins line up with state_q.
  always_comb begin
    pin_d    = '0;
    strobe_d = STROBE_IDLE;
    if (flag_en) begin
      pin_d.dout = amx_swap(flag_out_q);
      pin_d.oe   = amx_swap(flag_oe_q);
    end else if (port_en) begin
      case (state_d)
        st_addr: begin
          strobe_d.ale = 1'b1;
          pin_d.oe     = '1;
          if (state_q == st_idle ? sys_ctrl_q[WIDTH16_BIT] : xwide_q) begin
            pin_d.dout = state_q == st_idle ? bus_addr_q[15:0] : xaddr_q[15:0];
          end else begin
            pin_d.dout = state_q == st_idle ? bus_addr_q[23:8]
                                            : {xaddr_q[23:16], xaddr_q[15:8]};
          end
        end
        st_setup, st_strobe: begin
          if (state_d == st_strobe) begin
            strobe_d.rd_n = !xrd_q;
            strobe_d.wr_n = xrd_q;
          end
          if (xwide_q) begin
            pin_d.dout = xdata_q;
            pin_d.oe   = {16{!xrd_q}};
          end else begin
            pin_d.dout = {xaddr_q[7:0], xdata_q[7:0]};
            pin_d.oe   = {8'hff, {8{!xrd_q}}};
          end
        end
        default: pin_d = '0;
      endcase
    end
  end

  // Strobes are plain outputs with no enable, so they are driven at all times.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_data_pins_drive <= '0;
      bus_strobes          <= STROBE_IDLE;
    end else begin
      addr_data_pins_drive <= pin_d;
      bus_strobes          <= strobe_d;
    end
  end

  // Checks.
  logic [12:0] since_rst_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst_q <= '0;
    end else if (since_rst_q != 13'h1fff) begin
      since_rst_q <= since_rst_q + 13'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_addr_then_data;
    bus_strobes.ale [*2] ##1 !bus_strobes.ale;
  endsequence

  a_flag_map: assert property (
    flag_en |=> addr_data_pins_drive.dout == amx_swap($past(flag_out_q)))
    else $error("flag lines not mapped to swapped pins");

  a_flag_gate: assert property (
    !sys_ctrl_q[FLAG_MODE_BIT] && !port_en |=> addr_data_pins_drive.oe == '0)
    else $error("pins driven with neither flag mode nor port");

  a_addr8_phase: assert property (
    bus_strobes.ale && !xwide_q && flag_en == 1'b0 |->
      addr_data_pins_drive.dout == {xaddr_q[23:16], xaddr_q[15:8]}
      && addr_data_pins_drive.oe == '1)
    else $error("8-bit address phase wrong");

  a_addr16_phase: assert property (
    bus_strobes.ale && xwide_q |-> addr_data_pins_drive.dout == xaddr_q[15:0])
    else $error("16-bit address phase wrong");

  a_data8_phase: assert property (
    !bus_strobes.wr_n && !xwide_q |->
      addr_data_pins_drive.dout == {xaddr_q[7:0], xdata_q[7:0]}
      && addr_data_pins_drive.oe == '1)
    else $error("8-bit data phase wrong");

  a_data16_phase: assert property (
    !bus_strobes.rd_n && xwide_q |-> addr_data_pins_drive.oe == '0)
    else $error("16-bit read phase still drives pins");

  a_strobe_order: assert property (
    $rose(bus_strobes.ale) && port_en |-> s_addr_then_data)
    else $error("latch strobe not two cycles");

  a_write_width: assert property (
    !bus_strobes.wr_n |-> state_q == st_strobe && !xrd_q)
    else $error("write strobe malformed");

  a_wr_len: assert property (
    $fell(bus_strobes.wr_n) && port_en |-> !bus_strobes.wr_n [*6] ##1 bus_strobes.wr_n
      or !port_en [*1])
    else $error("write strobe length wrong");

  a_strobe_excl: assert property (
    !(bus_strobes.ale && (!bus_strobes.rd_n || !bus_strobes.wr_n))
      && (bus_strobes.rd_n || bus_strobes.wr_n))
    else $error("strobes overlap");

  a_lock_wait: assert property (
    $rose(core_run) |-> since_rst_q == 13'(LOCK_CYCLES))
    else $error("execution started at wrong time");

  a_no_early_go: assert property (
    !core_run |-> state_q == st_idle)
    else $error("bus cycle before lock");

  a_strap_hold: assert property (
    core_run && $past(core_run) |-> $stable(boot_mode) && $stable(core_ratio))
    else $error("straps changed after lock");

endmodule : amx_addr_data_mux

// *** amx_bus_partner.sv ***
// Far side of the parallel bus: an address latch and a small word memory.
// Assumes the bench resolves pin levels, with pull-ups on released lines, and sets the port width.
module amx_bus_partner (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Bus side
  input  wire logic [15:0]             pin_level,
  input  wire amx_pkg::amx_strobe_type bus_strobes,
  input  wire logic                    width16,
  output logic      [15:0]             part_dout,
  output logic      [15:0]             part_oe,
  // Observed words
  output logic      [15:0]             ale_word,
  output logic      [15:0]             wr_word,
  output logic      [7:0]              last_len
);
  timeunit 1ns;
  timeprecision 1ps;
  import amx_pkg::*;

  logic [15:0] mem [256];
  logic [7:0]  len_q;
  logic [7:0]  key;

  // The low address byte sits in the latch for 16-bit cycles and on the upper pins for 8-bit ones.
  assign key = width16 ? ale_word[7:0] : pin_level[15:8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ale_word <= 16'h0000;
      wr_word <= 16'h0000;
      len_q <= 8'h00;
      last_len <= 8'h00;
      part_oe <= 16'h0000;
      part_dout <= 16'h0000;
    end else begin
      if (bus_strobes.ale) begin
        ale_word <= pin_level;
      end
      if (!bus_strobes.wr_n) begin
        wr_word <= pin_level;
        mem[key] <= width16 ? pin_level : {8'h00, pin_level[7:0]};
      end
      // Data go out one cycle into the read strobe and are released one cycle after it ends.
      if (!bus_strobes.rd_n) begin
        part_oe <= width16 ? 16'hffff : 16'h00ff;
        part_dout <= mem[key];
      end else begin
        part_oe <= 16'h0000;
      end
      if (!bus_strobes.rd_n || !bus_strobes.wr_n) begin
        len_q <= len_q + 8'h01;
      end else begin
        len_q <= 8'h00;
        if (len_q != 8'h00) begin
          last_len <= len_q;
        end
      end
    end
  end
endmodule : amx_bus_partner

// *** tb_amx_addr_data_mux.sv ***
// Self-checking bench for the address/data pin mux: straps, lock wait, flag mode, bus cycles.
// Assumes the partner model on the pins and APB access from the first edge after reset.
module tb_amx_addr_data_mux;
  timeunit 1ns;
  timeprecision 1ps;
  import amx_pkg::*;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              width16;
  logic              err_q;
  logic              pready;
  logic              pslverr;
  logic              core_run;
  logic [7:0]        paddr;
  logic [7:0]        last_len;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd_q;
  logic [15:0]       pin_level;
  logic [15:0]       part_dout;
  logic [15:0]       part_oe;
  logic [15:0]       ale_word;
  logic [15:0]       wr_word;
  logic [1:0]        boot_st;
  logic [1:0]        ratio_st;
  logic [1:0]        r;
  amx_pin_drive_type drv;
  amx_strobe_type    stb;
  amx_boot_type      boot_mode;
  amx_ratio_type     core_ratio;
  amx_boot_type      boot_tab [4];
  amx_ratio_type     ratio_tab [4];
  int                err_total;
  int                checks;

  // Released lines float high through the pin pull-ups.
  assign pin_level = (drv.oe & drv.dout) | (~drv.oe & part_oe & part_dout) | (~drv.oe & ~part_oe);

  amx_addr_data_mux dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_data_pins_in(pin_level), .addr_data_pins_drive(drv), .bus_strobes(stb),
    .boot_select_straps(boot_st), .core_ratio_straps(ratio_st), .boot_mode(boot_mode),
    .core_ratio(core_ratio), .core_run(core_run)
  );

  amx_bus_partner partner (
    .pclk(pclk), .presetn(presetn), .pin_level(pin_level), .bus_strobes(stb), .width16(width16),
    .part_dout(part_dout), .part_oe(part_oe), .ale_word(ale_word), .wr_word(wr_word), .last_len(last_len)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      $display("[FAIL] pready expected 1 seen 0");
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd_q[ST_BUSY_BIT] !== 1'b0 && n < 40);
    if (rd_q[ST_BUSY_BIT] !== 1'b0) begin
      err_total++;
      $display("[FAIL] busy expected 0 seen 1");
    end
  endtask : wait_idle

  task automatic do_reset(input logic [1:0] b, input logic [1:0] rt);
    int n;
    @(posedge pclk);
    presetn <= 1'b0;
    boot_st <= b;
    ratio_st <= rt;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_run !== 1'b1 && n < 5000);
    `CHK("lock wait", 1'b1, (n >= LOCK_CYCLES && n <= LOCK_CYCLES + 2))
  endtask : do_reset

  initial begin
    #400000;
    err_total++;
    $display("[FAIL] watchdog expected end seen hang");
    test_done();
  end

  initial begin
    err_total = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    width16 = 1'b0;
    boot_st = 2'b00;
    ratio_st = 2'b00;
    boot_tab = '{boot_spi_slave, boot_spi_master, boot_parallel_eprom, boot_internal_rom};
    ratio_tab = '{ratio_3to1, ratio_16to1, ratio_8to1, ratio_3to1};
    // The reserved ratio code is never strapped, so the last pass reuses code 00.
    for (int i = 0; i < 4; i++) begin
      r = (i == 3) ? 2'b00 : 2'(i);
      do_reset(2'(i), r);
      `CHK("boot mode", boot_tab[i], boot_mode)
      `CHK("core ratio", ratio_tab[i], core_ratio)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status straps", {r, 2'b00, 2'(i), 2'b00, 2'b10}, rd_q[9:0])
      boot_st <= ~2'(i);
      ratio_st <= (r == 2'b00) ? 2'b01 : 2'b00;
      repeat (10) @(posedge pclk);
      `CHK("boot frozen", boot_tab[i], boot_mode)
      `CHK("ratio frozen", ratio_tab[i], core_ratio)
    end
    $display("test straps and lock done");
    apb(1'b1, OFS_SYS_CTRL, 32'h0010_0000);
    apb(1'b1, OFS_FLAG_OUT, 32'h12a5);
    apb(1'b1, OFS_FLAG_OE, 32'h00ff);
    repeat (2) @(posedge pclk);
    `CHK("flag dout", 16'ha512, drv.dout)
    `CHK("flag oe", 16'hff00, drv.oe)
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_FLAG_IN, 32'h0);
    `CHK("flag in", 32'h0000ffa5, rd_q)
    apb(1'b1, OFS_SYS_CTRL, 32'h0010_0001);
    repeat (2) @(posedge pclk);
    `CHK("flag with port", 1'b0, (drv.oe === 16'hff00))
    apb(1'b1, OFS_SYS_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("pins released", 16'h0000, drv.oe)
    $display("test flag mode done");
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped read", 1'b1, err_q)
    apb(1'b1, 8'h44, 32'h1);
    `CHK("unmapped write", 1'b1, err_q)
    $display("test unmapped done");
    for (int w = 0; w < 2; w++) begin
      width16 <= w[0];
      apb(1'b1, OFS_SYS_CTRL, {30'h0, w[0], 1'b1});
      apb(1'b1, OFS_BUS_ADDR, w ? 32'h00c3e7 : 32'habcdef);
      apb(1'b1, OFS_BUS_DATA, w ? 32'hbeef : 32'h005a);
      apb(1'b1, OFS_BUS_CMD, 32'h1);
      wait_idle();
      `CHK("latched address", w ? 16'hc3e7 : 16'habcd, ale_word)
      `CHK("write word", w ? 16'hbeef : 16'hef5a, wr_word)
      `CHK("strobe length", 8'(STROBE_CYCLES), last_len)
      apb(1'b1, OFS_BUS_DATA, 32'h0);
      apb(1'b1, OFS_BUS_CMD, 32'h3);
      wait_idle();
      apb(1'b0, OFS_BUS_DATA, 32'h0);
      `CHK("read back", w ? 32'hbeef : 32'h005a, rd_q)
      `CHK("strobes idle", STROBE_IDLE, stb)
      `CHK("bus released", 16'h0000, drv.oe)
      $display("test bus cycle width %0d done", w ? 16 : 8);
    end
    test_done();
  end
endmodule : tb_amx_addr_data_mux
